// *** core/sfdp_pkg.sv ***
// Purpose: constants and carrier types for the discovery table responder
// Assumes: single-wire serial mode 0, three address bytes, eight dummy clocks
// Notes: table contents live in the responder module itself
package sfdp_pkg;

  localparam logic [7:0] SFDP_READ_OPCODE = 8'h5A;
  localparam logic [4:0] SFDP_OPCODE_BITS = 5'h08;
  localparam logic [4:0] SFDP_ADDR_BITS = 5'h18;
  localparam logic [4:0] SFDP_DUMMY_BITS = 5'h08;
  localparam logic [7:0] SFDP_BLANK_BYTE = 8'hFF;
  localparam logic [7:0] SFDP_SIZE_TOP_512M = 8'h1F;
  localparam logic [7:0] SFDP_SIZE_TOP_1G = 8'h3F;
  localparam logic [7:0] SFDP_CHIP_ERASE_512M = 8'hE3;
  localparam logic [7:0] SFDP_CHIP_ERASE_1G = 8'hE6;
  localparam logic [14:0] SFDP_TABLE_LIMIT = 15'h0000;

  typedef enum logic [4:0] {
    SFDP_ST_OPCODE = 5'b00001,
    SFDP_ST_ADDR = 5'b00010,
    SFDP_ST_DUMMY = 5'b00100,
    SFDP_ST_DATA = 5'b01000,
    SFDP_ST_IGNORE = 5'b10000
  } sfdp_state_t;

  typedef struct packed {
    logic sck;
    logic cs_n;
    logic si;
  } sfdp_pins_t;

endpackage : sfdp_pkg

// *** core/sfdp_rom.sv ***
// Purpose: serial responder for the discovery parameter table of a quad serial flash
// Assumes: link clock well below a quarter of core_clk; pins are synchronised here
// Notes: unmapped table addresses answer FFh; the part size is a parameter
`timescale 1ns/100ps
`default_nettype none

// Contract
// R1 - table bytes 00h-03h return the signature S, F, D, P
// R2 - byte 04h returns minor revision 08h, byte 05h major revision 01h
// R3 - byte 06h returns header count 03h, zero based, four headers
// R4 - byte 07h returns FFh for the backward compatible access protocol
// R5 - header one: basic table ID 00h/FFh, rev 00h/01h, 14h DWORDs, at 0100h
// R6 - header two: ID 84h/FFh, rev 00h/01h, 02h DWORDs, at 0150h
// R7 - header three: ID 81h/FFh, rev 00h/01h, 16h DWORDs, at 1C8h
// R8 - header four: ID 87h/FFh, rev 00h/01h, 1Ch DWORDs, at 158h
// R9 - pointers are three bytes, low byte first, DWORD aligned
// R10 - byte 100h returns E7h
// R11 - byte 101h returns 20h and byte 103h returns FFh
// R12 - byte 102h returns FAh
// R13 - density DWORD zero based; top byte 1Fh for 512 Mb, 3Fh for 1 Gb
// R14 - bytes 108h, 109h return 48h and EBh
// R15 - bytes 10Ah, 10Bh return 08h and 6Bh
// R16 - bytes 10Ch-10Fh return 00h, FFh, 88h, BBh
// R17 - byte 110h FEh, 111h-115h and 117h FFh, 116h 00h
// R18 - bytes 118h-119h FFh, 11Ah 48h, 11Bh EBh
// R19 - erase types: 0Ch/20h, 00h/FFh, 00h/FFh, 12h/D8h
// R20 - bytes 124h-127h return 23h, FAh, FFh, 8Bh
// R21 - bytes 128h-12Ah 82h, E7h, FFh; 12Bh E3h or E6h by size
// R22 - bytes 12Ch, 12Dh return ECh and 23h
// R23 - bytes 130h-133h return 8Ah, 85h, 7Ah, 75h
// R24 - after the read command, ascending bytes, eight clocks each, until deselect
module sfdp_rom #(
  parameter bit GIG_PART = 1'b0
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic spi_sck,
  input wire logic spi_cs_n,
  input wire logic spi_si,
  output logic spi_so,
  output logic spi_so_oe
);

  // two-stage synchronisers; stage one is read by stage two only
  sfdp_pkg::sfdp_pins_t pins_in;
  sfdp_pkg::sfdp_pins_t meta_reg;
  sfdp_pkg::sfdp_pins_t sync_reg;
  logic sck_prev_reg;

  assign pins_in = '{sck: spi_sck, cs_n: spi_cs_n, si: spi_si};

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      meta_reg <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
      sync_reg <= '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
      sck_prev_reg <= 1'b0;
    end
    else
    begin
      meta_reg <= pins_in;
      sync_reg <= meta_reg;
      sck_prev_reg <= sync_reg.sck;
    end
  end

  wire logic sck_rise = sync_reg.sck & ~sck_prev_reg;
  wire logic sck_fall = ~sync_reg.sck & sck_prev_reg;
  wire logic deselected = sync_reg.cs_n;

  // table contents
  function automatic logic [7:0] table_byte(input logic [23:0] a, input bit gig);
    logic [7:0] b;
    b = sfdp_pkg::SFDP_BLANK_BYTE;
    if (a[23:9] == sfdp_pkg::SFDP_TABLE_LIMIT)
    begin
      case (a[8:0])
        9'h000: b = 8'h53; // R1
        9'h001: b = 8'h46; // R1
        9'h002: b = 8'h44; // R1
        9'h003: b = 8'h50; // R1
        9'h004: b = 8'h08; // R2
        9'h005: b = 8'h01; // R2
        9'h006: b = 8'h03; // R3
        9'h007: b = 8'hFF; // R4
        9'h008: b = 8'h00; // R5
        9'h009: b = 8'h00; // R5
        9'h00A: b = 8'h01; // R5
        9'h00B: b = 8'h14; // R5
        9'h00C: b = 8'h00; // R5 R9
        9'h00D: b = 8'h01; // R5 R9
        9'h00E: b = 8'h00; // R5 R9
        9'h00F: b = 8'hFF; // R5
        9'h010: b = 8'h84; // R6
        9'h011: b = 8'h00; // R6
        9'h012: b = 8'h01; // R6
        9'h013: b = 8'h02; // R6
        9'h014: b = 8'h50; // R6 R9
        9'h015: b = 8'h01; // R6 R9
        9'h016: b = 8'h00; // R6 R9
        9'h017: b = 8'hFF; // R6
        9'h018: b = 8'h81; // R7
        9'h019: b = 8'h00; // R7
        9'h01A: b = 8'h01; // R7
        9'h01B: b = 8'h16; // R7
        9'h01C: b = 8'hC8; // R7 R9
        9'h01D: b = 8'h01; // R7 R9
        9'h01E: b = 8'h00; // R7 R9
        9'h01F: b = 8'hFF; // R7
        9'h020: b = 8'h87; // R8
        9'h021: b = 8'h00; // R8
        9'h022: b = 8'h01; // R8
        9'h023: b = 8'h1C; // R8
        9'h024: b = 8'h58; // R8 R9
        9'h025: b = 8'h01; // R8 R9
        9'h026: b = 8'h00; // R8 R9
        9'h027: b = 8'hFF; // R8
        9'h100: b = 8'hE7; // R10
        9'h101: b = 8'h20; // R11
        9'h102: b = 8'hFA; // R12
        9'h103: b = 8'hFF; // R11
        9'h104: b = 8'hFF; // R13
        9'h105: b = 8'hFF; // R13
        9'h106: b = 8'hFF; // R13
        9'h107: b = gig ? sfdp_pkg::SFDP_SIZE_TOP_1G : sfdp_pkg::SFDP_SIZE_TOP_512M; // R13
        9'h108: b = 8'h48; // R14
        9'h109: b = 8'hEB; // R14
        9'h10A: b = 8'h08; // R15
        9'h10B: b = 8'h6B; // R15
        9'h10C: b = 8'h00; // R16
        9'h10D: b = 8'hFF; // R16
        9'h10E: b = 8'h88; // R16
        9'h10F: b = 8'hBB; // R16
        9'h110: b = 8'hFE; // R17
        9'h116: b = 8'h00; // R17
        9'h11A: b = 8'h48; // R18
        9'h11B: b = 8'hEB; // R18
        9'h11C: b = 8'h0C; // R19
        9'h11D: b = 8'h20; // R19
        9'h11E: b = 8'h00; // R19
        9'h120: b = 8'h00; // R19
        9'h122: b = 8'h12; // R19
        9'h123: b = 8'hD8; // R19
        9'h124: b = 8'h23; // R20
        9'h125: b = 8'hFA; // R20
        9'h126: b = 8'hFF; // R20
        9'h127: b = 8'h8B; // R20
        9'h128: b = 8'h82; // R21
        9'h129: b = 8'hE7; // R21
        9'h12A: b = 8'hFF; // R21
        9'h12B: b = gig ? sfdp_pkg::SFDP_CHIP_ERASE_1G : sfdp_pkg::SFDP_CHIP_ERASE_512M; // R21
        9'h12C: b = 8'hEC; // R22
        9'h12D: b = 8'h23; // R22
        9'h12E: b = 8'h19;
        9'h12F: b = 8'h49;
        9'h130: b = 8'h8A; // R23
        9'h131: b = 8'h85; // R23
        9'h132: b = 8'h7A; // R23
        9'h133: b = 8'h75; // R23
        default: b = sfdp_pkg::SFDP_BLANK_BYTE; // R17 R18 R19
      endcase
    end
    return b;
  endfunction : table_byte

  sfdp_pkg::sfdp_state_t state_reg;
  sfdp_pkg::sfdp_state_t state_next;
  logic [4:0] cnt_reg;
  logic [4:0] cnt_next;
  logic [23:0] shift_reg;
  logic [23:0] shift_next;
  logic [23:0] addr_reg;
  logic [23:0] addr_next;
  logic [2:0] bit_reg;
  logic [2:0] bit_next;
  logic so_reg;
  logic so_next;
  logic oe_reg;
  logic oe_next;

  wire logic [23:0] shift_in = {shift_reg[22:0], sync_reg.si};
  wire logic [7:0] rom_byte = table_byte(addr_reg, GIG_PART);
  wire logic data_phase = (state_reg == sfdp_pkg::SFDP_ST_DATA);
  wire logic last_bit = (bit_reg == 3'h7);
  wire logic [4:0] cnt_inc = cnt_reg + 5'h01;

  // serial front end: opcode, address, dummy, then streamed table data
  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    shift_next = shift_reg;
    addr_next = addr_reg;
    bit_next = bit_reg;
    so_next = so_reg;
    oe_next = oe_reg;
    if (deselected)
    begin
      // a frame ends only on deselect; the next frame starts from the opcode
      state_next = sfdp_pkg::SFDP_ST_OPCODE;
      cnt_next = 5'h00;
      bit_next = 3'h0;
      oe_next = 1'b0;
    end
    else if (sck_rise)
    begin
      case (state_reg)
        sfdp_pkg::SFDP_ST_OPCODE:
        begin
          shift_next = shift_in;
          cnt_next = cnt_inc;
          if (cnt_inc == sfdp_pkg::SFDP_OPCODE_BITS)
          begin
            cnt_next = 5'h00;
            state_next = (shift_in[7:0] == sfdp_pkg::SFDP_READ_OPCODE) ?
              sfdp_pkg::SFDP_ST_ADDR : sfdp_pkg::SFDP_ST_IGNORE;
          end
        end
        sfdp_pkg::SFDP_ST_ADDR:
        begin
          shift_next = shift_in;
          cnt_next = cnt_inc;
          if (cnt_inc == sfdp_pkg::SFDP_ADDR_BITS)
          begin
            cnt_next = 5'h00;
            addr_next = shift_in; // R24
            state_next = sfdp_pkg::SFDP_ST_DUMMY;
          end
        end
        sfdp_pkg::SFDP_ST_DUMMY:
        begin
          cnt_next = cnt_inc;
          if (cnt_inc == sfdp_pkg::SFDP_DUMMY_BITS)
          begin
            cnt_next = 5'h00;
            bit_next = 3'h0;
            state_next = sfdp_pkg::SFDP_ST_DATA;
          end
        end
        sfdp_pkg::SFDP_ST_DATA: state_next = state_reg;
        sfdp_pkg::SFDP_ST_IGNORE: state_next = state_reg;
        default: state_next = sfdp_pkg::SFDP_ST_IGNORE;
      endcase
    end
    else if (sck_fall && data_phase)
    begin
      // msb first on the falling edge so the host samples on the next rise
      so_next = rom_byte[3'h7 - bit_reg]; // R24
      oe_next = 1'b1;
      bit_next = bit_reg + 3'h1;
      if (last_bit)
      begin
        addr_next = addr_reg + 24'h000001; // R24
      end
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state_reg <= sfdp_pkg::SFDP_ST_OPCODE;
      cnt_reg <= 5'h00;
      shift_reg <= 24'h000000;
      addr_reg <= 24'h000000;
      bit_reg <= 3'h0;
      so_reg <= 1'b0;
      oe_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      shift_reg <= shift_next;
      addr_reg <= addr_next;
      bit_reg <= bit_next;
      so_reg <= so_next;
      oe_reg <= oe_next;
    end
  end

  assign spi_so = so_reg;
  assign spi_so_oe = oe_reg;

  // checks

  a_signature_bytes: assert property (@(posedge core_clk) disable iff (rst) // R1
    (addr_reg == 24'h000000) |-> (rom_byte == 8'h53))
    else $error("signature byte zero wrong");

  a_header_counts: assert property (@(posedge core_clk) disable iff (rst) // R3
    (addr_reg == 24'h000006) |-> (rom_byte == 8'h03))
    else $error("header count wrong");

  a_pointer_low: assert property (@(posedge core_clk) disable iff (rst) // R9
    (addr_reg == 24'h00001C) |-> (rom_byte == 8'hC8))
    else $error("sector map pointer low byte wrong");

  a_density_top: assert property (@(posedge core_clk) disable iff (rst) // R13
    (addr_reg == 24'h000107) |-> (rom_byte == (GIG_PART ? 8'h3F : 8'h1F)))
    else $error("density top byte wrong");

  a_suspend_ops: assert property (@(posedge core_clk) disable iff (rst) // R23
    (addr_reg == 24'h000133) |-> (rom_byte == 8'h75))
    else $error("erase suspend opcode wrong");

  a_bit_drive: assert property (@(posedge core_clk) disable iff (rst) // R24
    (sck_fall && data_phase && !deselected) |=>
      (spi_so == $past(rom_byte[3'h7 - bit_reg]) && spi_so_oe))
    else $error("data bit not driven from table");

  a_addr_step: assert property (@(posedge core_clk) disable iff (rst) // R24
    (sck_fall && data_phase && !deselected && last_bit) |=>
      (addr_reg == $past(addr_reg) + 24'h000001))
    else $error("address did not advance after a byte");

  a_release_quiet: assert property (@(posedge core_clk) disable iff (rst) // R24
    deselected |=> !spi_so_oe)
    else $error("output still enabled after deselect");

  sequence s_dummy_done;
    (state_reg == sfdp_pkg::SFDP_ST_DUMMY) && sck_rise && !deselected && (cnt_inc == sfdp_pkg::SFDP_DUMMY_BITS);
  endsequence

  a_data_entry: assert property (@(posedge core_clk) disable iff (rst) // R24
    s_dummy_done |=> data_phase && (bit_reg == 3'h0))
    else $error("data phase not entered after dummy clocks");

  a_foreign_silent: assert property (@(posedge core_clk) disable iff (rst) // R24
    (state_reg == sfdp_pkg::SFDP_ST_IGNORE) |-> !spi_so_oe)
    else $error("output enabled for a foreign command");

  sequence s_opcode_done;
    (state_reg == sfdp_pkg::SFDP_ST_OPCODE) && sck_rise && !deselected && (cnt_inc == sfdp_pkg::SFDP_OPCODE_BITS);
  endsequence

  // a foreign command must never reach the data phase, or this part would fight the real responder
  a_opcode_refuse: assert property (@(posedge core_clk) disable iff (rst) // R24
    s_opcode_done ##0 (shift_in[7:0] != sfdp_pkg::SFDP_READ_OPCODE) |=> (state_reg == sfdp_pkg::SFDP_ST_IGNORE))
    else $error("foreign opcode not refused");

  sequence s_addr_done;
    (state_reg == sfdp_pkg::SFDP_ST_ADDR) && sck_rise && !deselected && (cnt_inc == sfdp_pkg::SFDP_ADDR_BITS);
  endsequence

  a_addr_load: assert property (@(posedge core_clk) disable iff (rst) // R24
    s_addr_done |=> (addr_reg == $past(shift_in)) && (state_reg == sfdp_pkg::SFDP_ST_DUMMY))
    else $error("start address not taken after the address bits");

  a_revision_major: assert property (@(posedge core_clk) disable iff (rst) // R2
    (addr_reg == 24'h000005) |-> (rom_byte == 8'h01))
    else $error("major revision byte wrong");

  a_chip_erase: assert property (@(posedge core_clk) disable iff (rst) // R21
    (addr_reg == 24'h00012B) |-> (rom_byte == (GIG_PART ? 8'hE6 : 8'hE3)))
    else $error("chip erase timing byte wrong");

endmodule : sfdp_rom

`default_nettype wire

// *** testbench/sfdp_host.sv ***
// Purpose: host controller model issuing discovery reads to two responders
// Assumes: mode 0 link clock of eight core cycles, held low between frames
// Notes: both responders share the pins; their replies are captured side by side
`timescale 1ns/100ps
`default_nettype none
module sfdp_host (
  input wire logic core_clk,
  output var sfdp_pkg::sfdp_pins_t pins,
  input wire logic so_a,
  input wire logic so_b,
  input wire logic oe_a,
  input wire logic oe_b
);
  logic [7:0] rx_a [0:63];
  logic [7:0] rx_b [0:63];
  int oe_hits;
  logic oe_after;

  initial
  begin
    pins = '{sck: 1'b0, cs_n: 1'b1, si: 1'b0};
  end

  // read just before the fall, so the reply has had a full high phase to settle
  task automatic shift_bit(input logic b, output logic [1:0] r);
    pins.si <= b;
    repeat (4) @(posedge core_clk);
    pins.sck <= 1'b1;
    repeat (4) @(posedge core_clk);
    // an undriven line reads back inverted, so a missing enable shows up as bad data
    r = {oe_a ? so_a : ~so_a, oe_b ? so_b : ~so_b};
    if (oe_a === 1'b1 && oe_b === 1'b1)
      oe_hits++;
    pins.sck <= 1'b0;
  endtask : shift_bit

  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input int n);
    logic [31:0] cmd;
    logic [1:0] r;
    cmd = {op, addr};
    oe_hits = 0;
    @(posedge core_clk);
    pins.cs_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    for (int i = 31; i >= 0; i--)
      shift_bit(cmd[i], r);
    repeat (8) shift_bit(1'b0, r);
    for (int k = 0; k < n; k++)
    begin
      for (int i = 7; i >= 0; i--)
      begin
        // input line is a don't-care now, so it toggles rather than hold a value
        shift_bit(~pins.si, r);
        rx_a[k][i] = r[1];
        rx_b[k][i] = r[0];
      end
    end
    repeat (4) @(posedge core_clk);
    pins.cs_n <= 1'b1;
    repeat (8) @(posedge core_clk);
    oe_after = oe_a | oe_b;
  endtask : frame
endmodule : sfdp_host
`default_nettype wire

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench for the discovery table responder, both part sizes
// Assumes: host model drives the shared pins; expected bytes come from tables below
// Notes: unmapped addresses are expected to read FFh
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic core_clk;
  logic rst;
  sfdp_pkg::sfdp_pins_t pins;
  logic so_a;
  logic so_b;
  logic oe_a;
  logic oe_b;
  int bad_count;
  int samples_checked;
  int seed;
  logic [23:0] ptr;
  localparam logic [319:0] HDR = {160'h53464450_080103FF_00000114_000100FF_84000102,
    160'h500100FF_81000116_C80100FF_8700011C_580100FF};
  localparam logic [415:0] BASIC = {128'hE720FAFF_FFFFFF1F_48EB086B_00FF88BB, 128'hFEFFFFFF_FFFF00FF_FFFF48EB_0C2000FF,
    128'h00FF12D8_23FAFF8B_82E7FFE3_EC231949, 32'h8A857A75};
  localparam logic [63:0] PTRS = 64'h0100_0150_01C8_0158;

  sfdp_rom #(.GIG_PART(1'b0)) u_sfdp_rom (.core_clk(core_clk), .rst(rst), .spi_sck(pins.sck),
    .spi_cs_n(pins.cs_n), .spi_si(pins.si), .spi_so(so_a), .spi_so_oe(oe_a));
  sfdp_rom #(.GIG_PART(1'b1)) u_sfdp_rom_gig (.core_clk(core_clk), .rst(rst), .spi_sck(pins.sck),
    .spi_cs_n(pins.cs_n), .spi_si(pins.si), .spi_so(so_b), .spi_so_oe(oe_b));
  sfdp_host u_host (.core_clk(core_clk), .pins(pins), .so_a(so_a), .so_b(so_b), .oe_a(oe_a), .oe_b(oe_b));

  initial
  begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  function automatic logic [7:0] exp_byte(input logic [23:0] a, input logic gig);
    int i;
    logic [7:0] v;
    i = int'(a);
    v = 8'hFF;
    if (a < 24'h000028)
      v = HDR[(39 - i) * 8 +: 8];
    else if (a >= 24'h000100 && a < 24'h000134)
      v = BASIC[(307 - i) * 8 +: 8];
    if (gig && a == 24'h000107)
      v = 8'h3F;
    if (gig && a == 24'h00012B)
      v = 8'hE6;
    return v;
  endfunction : exp_byte

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic run(input logic [7:0] op, input logic [23:0] addr, input int n);
    u_host.frame(op, addr, n);
    for (int k = 0; k < n; k++)
    begin
      if (op == 8'h5A)
      begin
        check({8'h00, u_host.rx_a[k]}, {8'h00, exp_byte(addr + 24'(k), 1'b0)});
        check({8'h00, u_host.rx_b[k]}, {8'h00, exp_byte(addr + 24'(k), 1'b1)});
      end
    end
    check(16'(u_host.oe_hits), (op == 8'h5A) ? 16'(n * 8) : 16'h0000);
    check({15'h0000, u_host.oe_after}, 16'h0000);
  endtask : run

  task automatic end_of_test;
    $display("checked %0d samples, %0d mismatches", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_of_test

  initial
  begin
    seed = 91;
    bad_count = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (16) @(posedge core_clk);
    rst <= 1'b0;
    repeat (4) @(posedge core_clk);
    run(8'h5A, 24'h000000, 40);
    $display("header read done");
    run(8'h5A, 24'h000100, 52);
    $display("basic table read done");
    for (int h = 0; h < 4; h++)
    begin
      run(8'h5A, 24'(8 * h + 12), 3);
      ptr = {u_host.rx_a[2], u_host.rx_a[1], u_host.rx_a[0]};
      check(ptr[15:0], PTRS[(3 - h) * 16 +: 16]);
      check({14'h0000, ptr[1:0]}, 16'h0000);
      run(8'h5A, ptr, 4);
    end
    $display("pointer chase done");
    for (int b = 0; b < 4; b++)
      run(8'h5A ^ (8'h01 << b), 24'h000000, 2);
    $display("refused opcodes done");
    run(8'h5A, 24'h000104, 0);
    $display("short frame done");
    run(8'h5A, 24'hFFFFFE, 4);
    $display("address wrap done");
    for (int j = 0; j < 12; j++)
      run(8'h5A, 24'($unsigned($random(seed))) & 24'h0001FF, 1 + int'($unsigned($random(seed)) % 4));
    $display("random reads done");
    end_of_test;
  end

  initial
  begin
    repeat (60000) @(posedge core_clk);
    bad_count++;
    $display("timeout: run exceeded its cycle limit");
    end_of_test;
  end
endmodule : tb_top
`default_nettype wire
